// [daq_host.sv]
module daq_host
    import daq_pkg::*;
(
    input wire logic mclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle from time zero
    initial begin
        {psel, penable, pwrite} = 3'b000;
        paddr = 10'h000;
        pwdata = 32'h0000_0000;
    end

    // One transfer; an idle cycle follows so no signal is driven twice in a step
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        // Only the bench watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        pwdata <= ~wd; // Released data must not look valid
        @(posedge mclk);
    endtask
endmodule

// [daq_output_config_status.sv]
// Contract
// - Hold bit blocks DAC updates and FIFO writes
// - Buffer-off bit bypasses double buffering, deglitching
// - Cyclic halt set: stop at buffer end
// - Cyclic halt clear: restart buffer after last point
// - Halt bit acts only cyclic, FIFO-resident data
// - Select set: request at half full until empty
// - Select clear: request while FIFO non-empty
// - Source 3 route: retransmit or scan pulse
// - Gate 2 route: counter output 1 or internal
// - DMA DAC writes always go through FIFO
// - Path bit steers programmed writes: FIFO/direct
// - Mask bit ignores active-low external trigger
// - Read-only 16-bit status word at 0x18
// - Done flag marks end, clean or error
// - Done plus request enable: request until empty
// - Done stays set until clear strobe
// - In-progress flag set while acquisition runs
// - Half-full flag low at 256 or more
// - Empty flag low when empty; no request
// - Overflow ends acquisition, sets overflow flag
module daq_output_config_status
    import daq_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic adc_result_valid,
    input wire logic [15:0] adc_result,
    input wire logic adc_overrun,
    input wire logic acq_last_conversion,
    input wire logic external_trigger_n,
    input wire logic adc_request_enable,
    output logic adc_request,
    output logic acquisition_start,
    input wire logic dac_pio_write,
    input wire logic dac_dma_write,
    input wire logic dac_update_tick,
    output logic dac_fifo_write,
    output logic dac_direct_write,
    output logic dac_update,
    output logic double_buffer_off,
    input wire logic dac_cyclic_mode,
    input wire logic dac_fifo_only,
    input wire logic dac_end_of_buffer,
    input wire logic dac_sequence_start,
    output logic dac_retransmit,
    output logic dac_halt,
    input wire logic scan_pulse,
    input wire logic counter_out1,
    input wire logic internal_gate2,
    output logic counter_source3,
    output logic counter_gate2
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // Byte address to register index; the low two bits are dropped here, is_mapped rejects unaligned addresses
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        return a[9:2];
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a, input logic wr);
        logic [7:0] i;
        i = reg_index(a);
        if (a[1:0] != 2'b00) begin
            return 1'b0;
        end else if (i == IDX_ADC_DATA || i == IDX_STATUS) begin
            return !wr;
        end else if (i == IDX_CTRL || i == IDX_ACQ_CLEAR || i == IDX_ACQ_START) begin
            return wr;
        end else begin
            return 1'b0;
        end
    endfunction

    daq_ctrl_t ctrl_q;
    daq_flags_t flags_q;
    daq_acq_state_t acq_q;
    logic [15:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic half_hold_q;
    logic trig_n_q;
    logic setup;
    logic done_xfer;
    logic wr_ok;
    logic rd_ok;
    logic pop;
    logic push;
    logic overflow_ev;
    logic clear_strobe;
    logic start_strobe;
    logic trig_ev;
    logic start_ev;
    logic end_ev;
    logic [15:0] status_word;
    logic [7:0] idx;
    logic nonempty;

    assign idx = reg_index(paddr);
    assign setup = psel && !penable;
    // Transfer completes at the access edge on which pready is seen high
    assign done_xfer = psel && penable && pready;
    assign wr_ok = done_xfer && pwrite && !pslverr;
    assign rd_ok = done_xfer && !pwrite && !pslverr;
    assign clear_strobe = wr_ok && idx == IDX_ACQ_CLEAR;
    assign start_strobe = wr_ok && idx == IDX_ACQ_START;
    assign nonempty = count_q != '0;

    // Only data-register reads pop; status reads are free of side effects
    assign pop = rd_ok && idx == IDX_ADC_DATA && nonempty;

    ////////////////////////////////////////////////////////////////////////////
    // Status word assembly

    always_comb begin
        status_word = STATUS_RESERVED;
        status_word[ST_DONE] = flags_q.done;
        status_word[ST_PROG] = acq_q == ACQ_RUN;
        status_word[ST_HALF_N] = count_q < FIFO_HALF;
        status_word[ST_EMPTY_N] = nonempty;
        status_word[ST_OVERFLOW] = flags_q.overflow;
        status_word[ST_OVERRUN] = flags_q.overrun;
    end

    // Answer one cycle after setup: every bus output comes from a flop
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !is_mapped(paddr, pwrite);
        end
    end

    // Read data captured in setup; write-only registers read as zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite && idx == IDX_STATUS) begin
            prdata <= {16'h0000, status_word};
        end else if (setup && !pwrite && idx == IDX_ADC_DATA) begin
            prdata <= {16'h0000, fifo_mem[rd_ptr_q]};
        end else if (setup) begin
            prdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output control byte

    // Reset clears it, but software still owns initialisation after power-up
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ok && idx == IDX_CTRL) begin
            ctrl_q <= daq_ctrl_t'(pwdata[7:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ADC result FIFO

    // A push into a full buffer is dropped, and reported as overflow only while an acquisition runs
    assign push = adc_result_valid && (count_q != FIFO_FULL);
    assign overflow_ev = adc_result_valid && (count_q == FIFO_FULL) && acq_q == ACQ_RUN;

    always_ff @(posedge mclk) begin
        if (push) begin
            fifo_mem[wr_ptr_q] <= adc_result;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + PTR_ONE;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + PTR_ONE;
            end
            if (push && !pop) begin
                count_q <= count_q + CNT_ONE;
            end else if (pop && !push) begin
                count_q <= count_q - CNT_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acquisition sequencing

    // Trigger acts on the falling edge of the active-low input
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            trig_n_q <= 1'b1;
        end else begin
            trig_n_q <= external_trigger_n;
        end
    end

    assign trig_ev = trig_n_q && !external_trigger_n && !ctrl_q.ext_trigger_mask;
    assign start_ev = acq_q == ACQ_IDLE && (trig_ev || start_strobe);
    // Errors stop the run in the same cycle they are seen
    assign end_ev = acq_q == ACQ_RUN && (acq_last_conversion || overflow_ev || adc_overrun);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            acq_q <= ACQ_IDLE;
        end else begin
            case (acq_q)
                ACQ_IDLE: begin
                    if (start_ev) begin
                        acq_q <= ACQ_RUN;
                    end
                end
                ACQ_RUN: begin
                    if (end_ev) begin
                        acq_q <= ACQ_IDLE;
                    end
                end
                default: begin
                    acq_q <= ACQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            acquisition_start <= 1'b0;
        end else begin
            acquisition_start <= start_ev;
        end
    end

    // Sticky flags; a new event in the clear cycle wins over the clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flags_q <= '0;
        end else begin
            if (end_ev) begin
                flags_q.done <= 1'b1;
            end else if (clear_strobe) begin
                flags_q.done <= 1'b0;
            end
            if (overflow_ev) begin
                flags_q.overflow <= 1'b1;
            end else if (clear_strobe) begin
                flags_q.overflow <= 1'b0;
            end
            if (adc_overrun) begin
                flags_q.overrun <= 1'b1;
            end else if (clear_strobe) begin
                flags_q.overrun <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ADC request generation

    // Half-full mode latches on reaching 256 and lets go only when drained
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            half_hold_q <= 1'b0;
        end else if (!nonempty) begin
            half_hold_q <= 1'b0;
        end else if (count_q >= FIFO_HALF) begin
            half_hold_q <= 1'b1;
        end
    end

    // Host drains the FIFO through the data register to drop the request
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            adc_request <= 1'b0;
        end else if (!nonempty) begin
            adc_request <= 1'b0;
        end else if (flags_q.done && adc_request_enable) begin
            adc_request <= 1'b1;
        end else if (ctrl_q.adc_request_select) begin
            adc_request <= half_hold_q || count_q >= FIFO_HALF;
        end else begin
            adc_request <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // DAC write and update gating

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dac_fifo_write <= 1'b0;
            dac_direct_write <= 1'b0;
            dac_update <= 1'b0;
            double_buffer_off <= 1'b0;
        end else begin
            // DMA always through the FIFO; hold blocks only the FIFO path
            dac_fifo_write <= !ctrl_q.dac_update_hold
                && (dac_dma_write || (dac_pio_write && ctrl_q.pio_via_fifo));
            // Direct writes still land while updates are held
            dac_direct_write <= dac_pio_write && !ctrl_q.pio_via_fifo;
            dac_update <= dac_update_tick && !ctrl_q.dac_update_hold;
            double_buffer_off <= ctrl_q.double_buffer_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cyclic buffer end handling

    // Outside cyclic FIFO-resident mode the end of buffer is left to the
    // sequencer; this logic neither halts nor retransmits then
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dac_retransmit <= 1'b0;
            dac_halt <= 1'b0;
        end else begin
            dac_retransmit <= dac_end_of_buffer && dac_cyclic_mode && dac_fifo_only
                && !ctrl_q.cyclic_halt_enable;
            if (dac_end_of_buffer && dac_cyclic_mode && dac_fifo_only
                && ctrl_q.cyclic_halt_enable) begin
                dac_halt <= 1'b1;
            end else if (dac_sequence_start) begin
                dac_halt <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter source and gate routing

    // Registered to keep outputs on flops; costs one cycle of latency
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            counter_source3 <= 1'b0;
            counter_gate2 <= 1'b0;
        end else begin
            counter_source3 <= ctrl_q.counter_source3_route ? dac_retransmit : scan_pulse;
            counter_gate2 <= ctrl_q.counter_gate2_route ? counter_out1 : internal_gate2;
        end
    end

endmodule

// [daq_output_config_status_checker.sv]
module daq_chk
    import daq_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic adc_result_valid,
    input wire logic external_trigger_n,
    input wire logic adc_request,
    input wire logic acquisition_start,
    input wire logic dac_pio_write,
    input wire logic dac_dma_write,
    input wire logic dac_update_tick,
    input wire logic dac_fifo_write,
    input wire logic dac_direct_write,
    input wire logic dac_update,
    input wire logic scan_pulse,
    input wire logic counter_out1,
    input wire logic internal_gate2,
    input wire logic counter_source3,
    input wire logic counter_gate2
);
    daq_ctrl_t ctrl_q;
    logic [CNT_W-1:0] cnt_q;
    logic acc;
    logic push;
    logic pop;

    // Completed bus access; pushes into a full buffer are dropped
    assign acc = psel && penable && pready;
    assign push = adc_result_valid && (cnt_q < FIFO_FULL);
    assign pop = acc && !pwrite && (paddr == {IDX_ADC_DATA, 2'b00}) && (cnt_q != '0);

    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the control byte, seen only through bus writes
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= daq_ctrl_t'(CTRL_RESET);
        end else if (acc && pwrite && paddr == {IDX_CTRL, 2'b00}) begin
            ctrl_q <= daq_ctrl_t'(pwdata[7:0]);
        end
    end

    // Shadow fill level, so request rules can be judged from the ports
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(push) - CNT_W'(pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_masked_trigger;
        ctrl_q.ext_trigger_mask && $fell(external_trigger_n);
    endsequence

    property p_ready;
        s_setup |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access not answered");
    property p_ro;
        acc && pwrite && paddr == {IDX_STATUS, 2'b00} |-> pslverr;
    endproperty
    a_ro: assert property (p_ro) else $error("status write accepted");
    property p_hold;
        ctrl_q.dac_update_hold && dac_update_tick |=> !dac_update;
    endproperty
    a_hold: assert property (p_hold) else $error("update while held");
    property p_dma;
        !ctrl_q.dac_update_hold && dac_dma_write |=> dac_fifo_write;
    endproperty
    a_dma: assert property (p_dma) else $error("dma write bypassed buffer");
    property p_pio;
        !ctrl_q.pio_via_fifo && !dac_dma_write && dac_pio_write |=> dac_direct_write && !dac_fifo_write;
    endproperty
    a_pio: assert property (p_pio) else $error("programmed write misrouted");
    property p_gate2;
        counter_gate2 == ($past(ctrl_q.counter_gate2_route) ? $past(counter_out1) : $past(internal_gate2));
    endproperty
    a_gate2: assert property (p_gate2) else $error("gate 2 misrouted");
    property p_src3;
        !$past(ctrl_q.counter_source3_route) |-> counter_source3 == $past(scan_pulse);
    endproperty
    a_src3: assert property (p_src3) else $error("source 3 misrouted");
    property p_mask;
        s_masked_trigger |=> !acquisition_start [*3];
    endproperty
    a_mask: assert property (p_mask) else $error("masked trigger started run");
    property p_half;
        ctrl_q.adc_request_select && cnt_q >= FIFO_HALF |=> adc_request;
    endproperty
    a_half: assert property (p_half) else $error("no request at half full");
    property p_one;
        !ctrl_q.adc_request_select && cnt_q != '0 |=> adc_request;
    endproperty
    a_one: assert property (p_one) else $error("no request with data held");
    property p_empty;
        cnt_q == '0 |=> !adc_request;
    endproperty
    a_empty: assert property (p_empty) else $error("request while empty");
endmodule

bind daq_output_config_status daq_chk i_daq_chk (.*);

// [daq_pkg.sv]
package daq_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_ADC_DATA = 8'h00;
    localparam logic [7:0] IDX_CTRL = 8'h06;
    localparam logic [7:0] IDX_STATUS = 8'h18;
    localparam logic [7:0] IDX_ACQ_CLEAR = 8'h1A;
    localparam logic [7:0] IDX_ACQ_START = 8'h1C;
    localparam int ADDR_W = 10;

    // Status word field positions
    localparam int ST_DONE = 15;
    localparam int ST_PROG = 14;
    localparam int ST_HALF_N = 13;
    localparam int ST_EMPTY_N = 12;
    localparam int ST_OVERFLOW = 9;
    localparam int ST_OVERRUN = 8;

    // ADC result buffer geometry
    localparam int FIFO_DEPTH = 512;
    localparam int PTR_W = 9;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] FIFO_HALF = 10'h100;
    localparam logic [CNT_W-1:0] FIFO_FULL = 10'h200;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    localparam logic [PTR_W-1:0] PTR_ONE = 9'h001;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] STATUS_RESERVED = 16'h0000;

    // Low byte of the output control word, bit 7 first
    typedef struct packed {
        logic dac_update_hold;
        logic double_buffer_off;
        logic cyclic_halt_enable;
        logic adc_request_select;
        logic counter_source3_route;
        logic counter_gate2_route;
        logic pio_via_fifo;
        logic ext_trigger_mask;
    } daq_ctrl_t;

    // Acquisition sticky flags
    typedef struct packed {
        logic done;
        logic overflow;
        logic overrun;
    } daq_flags_t;

    typedef enum logic {ACQ_IDLE, ACQ_RUN} daq_acq_state_t;

endpackage

// [test_daq_output_config_status.sv]
module test_daq_output_config_status
    import daq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic reset_n, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic adc_result_valid, adc_overrun, acq_last_conversion, external_trigger_n;
    logic [15:0] adc_result;
    logic adc_request_enable, adc_request, acquisition_start, dac_pio_write;
    logic dac_dma_write, dac_update_tick, dac_fifo_write, dac_direct_write, dac_update;
    logic double_buffer_off, dac_cyclic_mode, dac_fifo_only, dac_end_of_buffer;
    logic dac_sequence_start, dac_retransmit, dac_halt, scan_pulse, counter_out1;
    logic internal_gate2, counter_source3, counter_gate2;
    int miscompares = 0;
    int num_checks = 0;

    daq_output_config_status i_daq_output_config_status (.*);
    daq_host i_daq_host (.*);

    // Free-running board clock
    always #2 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        i_daq_host.xfer(1'b1, idx, d, r, e);
    endtask
    task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        i_daq_host.xfer(1'b0, idx, 32'h0000_0000, r, e);
        chk(nm, r, exp);
    endtask
    task automatic req(input logic exp);
        chk("request", {31'h0, adc_request}, {31'h0, exp});
    endtask
    // Back-to-back results with a running count as data
    task automatic push(input int n, input int base);
        for (int i = 0; i < n; i++) begin
            adc_result_valid <= 1'b1;
            adc_result <= 16'(base + i);
            @(posedge mclk);
        end
        adc_result_valid <= 1'b0;
        @(posedge mclk);
    endtask
    // 00 trigger fall, 01 overrun, 10 last conversion
    task automatic ev(input logic [1:0] v);
        {acq_last_conversion, adc_overrun} <= v;
        external_trigger_n <= (v != 2'b00);
        @(posedge mclk);
        {acq_last_conversion, adc_overrun} <= 2'b00;
        external_trigger_n <= 1'b1;
        tick(2);
    endtask
    // Control byte, then strobes {pio, dma, tick}; outputs {fifo, direct, update}
    task automatic dac_try(input logic [7:0] c, input logic [2:0] s, input logic [2:0] exp);
        wr(IDX_CTRL, {24'h000000, c});
        {dac_pio_write, dac_dma_write, dac_update_tick} <= s;
        @(posedge mclk);
        {dac_pio_write, dac_dma_write, dac_update_tick} <= 3'b000;
        @(posedge mclk);
        chk("dac strobes", {29'h0, dac_fifo_write, dac_direct_write, dac_update}, {29'h0, exp});
    endtask
    // End of buffer pulse; outputs {retransmit, halt} one cycle later
    task automatic eob(input logic [1:0] exp);
        dac_end_of_buffer <= 1'b1;
        @(posedge mclk);
        dac_end_of_buffer <= 1'b0;
        @(posedge mclk);
        chk("buffer end", {30'h0, dac_retransmit, dac_halt}, {30'h0, exp});
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        final_report();
    end

    initial begin
        logic [31:0] r;
        logic e;
        adc_result = 16'h0000;
        {adc_result_valid, adc_overrun, acq_last_conversion, adc_request_enable} = 4'h0;
        {dac_pio_write, dac_dma_write, dac_update_tick, dac_cyclic_mode} = 4'h0;
        {dac_fifo_only, dac_end_of_buffer, dac_sequence_start} = 3'h0;
        {scan_pulse, counter_out1, internal_gate2} = 3'h0;
        external_trigger_n = 1'b1;
        reset_n = 1'b0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rdc("status", IDX_STATUS, 32'h0000_2000);
        i_daq_host.xfer(1'b1, IDX_STATUS, 32'h0000_FFFF, r, e);
        chk("status write error", {31'h0, e}, 32'h0000_0001);
        i_daq_host.xfer(1'b0, 8'h3F, 32'h0000_0000, r, e);
        chk("unmapped error", {31'h0, e}, 32'h0000_0001);
        $display("register map test done");
        {scan_pulse, counter_out1} <= 2'b11;
        dac_try(8'h83, 3'b101, 3'b000);
        dac_try(8'h42, 3'b100, 3'b100);
        chk("buffer off", {31'h0, double_buffer_off}, 32'h0000_0001);
        dac_try(8'h04, 3'b010, 3'b100);
        chk("gate2", {31'h0, counter_gate2}, 32'h0000_0001);
        chk("source3", {31'h0, counter_source3}, 32'h0000_0001);
        dac_try(8'h00, 3'b101, 3'b011);
        chk("gate2", {31'h0, counter_gate2}, 32'h0000_0000);
        chk("buffer off", {31'h0, double_buffer_off}, 32'h0000_0000);
        $display("output control test done");
        wr(IDX_CTRL, 32'h0000_0001);
        ev(2'b00);
        rdc("status", IDX_STATUS, 32'h0000_2000);
        wr(IDX_CTRL, 32'h0000_0000);
        ev(2'b00);
        rdc("status", IDX_STATUS, 32'h0000_6000);
        ev(2'b10);
        rdc("status", IDX_STATUS, 32'h0000_A000);
        rdc("status", IDX_STATUS, 32'h0000_A000);
        adc_request_enable <= 1'b1;
        wr(IDX_CTRL, 32'h0000_0010);
        push(1, 9);
        tick(1);
        req(1'b1);
        rdc("adc data", IDX_ADC_DATA, 32'h0000_0009);
        adc_request_enable <= 1'b0;
        wr(IDX_ACQ_CLEAR, 32'h0000_0000);
        rdc("status", IDX_STATUS, 32'h0000_2000);
        ev(2'b00);
        ev(2'b01);
        rdc("status", IDX_STATUS, 32'h0000_A100);
        wr(IDX_ACQ_CLEAR, 32'h0000_0000);
        $display("acquisition test done");
        ev(2'b00);
        push(255, 0);
        tick(1);
        req(1'b0);
        rdc("status", IDX_STATUS, 32'h0000_7000);
        push(1, 255);
        tick(1);
        req(1'b1);
        rdc("status", IDX_STATUS, 32'h0000_5000);
        push(257, 256);
        rdc("status", IDX_STATUS, 32'h0000_9200);
        // Host drains the whole buffer to retire the request
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            rdc("adc data", IDX_ADC_DATA, 32'(i));
            if (i == 300) begin
                req(1'b1);
            end
        end
        tick(1);
        req(1'b0);
        rdc("status", IDX_STATUS, 32'h0000_A200);
        wr(IDX_ACQ_CLEAR, 32'h0000_0000);
        rdc("status", IDX_STATUS, 32'h0000_2000);
        wr(IDX_CTRL, 32'h0000_0000);
        push(1, 7);
        tick(1);
        req(1'b1);
        rdc("adc data", IDX_ADC_DATA, 32'h0000_0007);
        tick(1);
        req(1'b0);
        $display("buffer request test done");
        wr(IDX_ACQ_START, 32'h0000_0000);
        rdc("status", IDX_STATUS, 32'h0000_6000);
        ev(2'b10);
        rdc("status", IDX_STATUS, 32'h0000_A000);
        wr(IDX_ACQ_CLEAR, 32'h0000_0000);
        // Cyclic FIFO-resident buffer: restart, ignore outside mode, then halt
        {dac_cyclic_mode, dac_fifo_only, scan_pulse} <= 3'b110;
        wr(IDX_CTRL, 32'h0000_0008);
        eob(2'b10);
        tick(1);
        chk("source3", {31'h0, counter_source3}, 32'h0000_0001);
        dac_fifo_only <= 1'b0;
        wr(IDX_CTRL, 32'h0000_0020);
        eob(2'b00);
        dac_fifo_only <= 1'b1;
        eob(2'b01);
        dac_sequence_start <= 1'b1;
        tick(1);
        dac_sequence_start <= 1'b0;
        tick(1);
        chk("halt", {31'h0, dac_halt}, 32'h0000_0000);
        $display("cyclic test done");
        final_report();
    end
endmodule
